//--- core/cmbf_core.sv
// CAN message buffers: three transmit buffers, five-stage receive FIFO,
// identifier acceptance filter, AXI4-Lite register slave
// assumes the protocol engine runs on clk_sys_i and gives one-cycle pulses
//
// Behaviour
// - three transmit buffers with frame, 8-bit local priority and time stamp
// - successful send sets the empty flag; transmit interrupt unless masked
// - among pending buffers the numerically lowest priority value is sent
// - equal lowest priority goes to the lower buffer index
// - prioritisation reruns at every arbitration, retries included
// - abort request of an idle pending buffer sets ack, empty, interrupt
// - released buffer shows ack 1 when aborted, 0 when sent
// - five-stage receive FIFO; only the foreground is software visible
// - each receive buffer holds control, identifier, data, time stamp
// - accepted valid frame moves into FIFO, sets full flag, interrupt
// - invalid or rejected frames are not moved and get overwritten
// - own frame captured but not queued, no interrupt, no acknowledge
// - loopback treats own frames as received; lost arbitration receives
// - full FIFO drops accepted frame, flags overrun, reception resumes later
// - identifier compared against pattern; mask bits set mean don't care
// - acceptance reports matching section in hit index; lowest wins
// - two-filter mode compares whole 32-bit banks, hits 0 and 1
// - four-filter mode compares 16-bit halves, hits 0-1 and 2-3
// - eight-filter mode compares first identifier byte, hits 0-3 and 4-7
// - closed filter accepts nothing and never sets the full flag
// - with time stamping on, timer value stored after end of frame
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module cmbf_core (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_b_i,
  input  wire logic [7:0]               s_axi_awaddr_i,
  input  wire logic                     s_axi_awvalid_i,
  output logic                          s_axi_awready_o,
  input  wire logic [31:0]              s_axi_wdata_i,
  input  wire logic [3:0]               s_axi_wstrb_i,
  input  wire logic                     s_axi_wvalid_i,
  output logic                          s_axi_wready_o,
  output logic [1:0]                    s_axi_bresp_o,
  output logic                          s_axi_bvalid_o,
  input  wire logic                     s_axi_bready_i,
  input  wire logic [7:0]               s_axi_araddr_i,
  input  wire logic                     s_axi_arvalid_i,
  output logic                          s_axi_arready_o,
  output logic [31:0]                   s_axi_rdata_o,
  output logic [1:0]                    s_axi_rresp_o,
  output logic                          s_axi_rvalid_o,
  input  wire logic                     s_axi_rready_i,
  input  wire logic                     tx_arb_i,
  input  wire logic                     tx_done_i,
  input  wire logic                     tx_err_i,
  input  wire logic                     tx_lost_i,
  output logic                          tx_pend_o,
  output cmbf_pkg::cmbf_frame_type      tx_frame_o,
  input  wire logic                     rx_eof_i,
  input  wire logic                     rx_ok_i,
  input  wire cmbf_pkg::cmbf_frame_type rx_frame_i,
  input  wire logic [15:0]              ts_i,
  output logic                          ack_en_o,
  output logic                          tx_irq_o,
  output logic                          rx_irq_o,
  output logic                          ovr_irq_o
);
  import cmbf_pkg::*;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  logic [31:0]    ctrl_r;
  logic [31:0]    ien_r;
  logic [31:0]    pat_r [2];
  logic [31:0]    msk_r [2];
  cmbf_txbuf_type txb_r [NTX];
  logic [NTX-1:0] empty_r;
  logic [NTX-1:0] abort_ack_r;
  logic [NTX-1:0] abort_request_r;
  logic [NTX-1:0] sel_r;
  logic [NTX-1:0] abort_ok_w;
  logic [NTX-1:0] done_w;
  logic [NTX-1:0] txe_clr_w;
  logic [NTX-1:0] abt_set_w;
  logic           tx_active_r;
  logic [1:0]     tx_cur_r;
  logic [1:0]     best_w;
  logic           best_v_w;
  logic           local_priority_ok_w;
  cmbf_rxmsg_type fifo_r [NRX];
  cmbf_rxmsg_type bg_r;
  cmbf_rxmsg_type head_w;
  logic           push_r;
  logic [2:0]     rd_ptr_r;
  logic [2:0]     wr_ptr_r;
  logic [2:0]     rx_cnt_r;
  logic           ovr_r;
  logic           pop_w;
  cmbf_fmode_type fmode_w;
  logic [31:0]    idrep_w;
  logic [31:0]    eq_w [2];
  logic [7:0]     hit_w;
  logic           acc_w;
  logic           aw_have_r;
  logic           w_have_r;
  logic [7:0]     wa_r;
  logic [31:0]    wd_r;
  logic [3:0]     ws_r;
  logic           bvalid_r;
  logic           rvalid_r;
  logic           wr_en_w;
  logic [31:0]    rdat_w;
  logic [1:0]     tsel_w;

  function automatic logic [2:0] first_idx(input logic [7:0] v);
    first_idx = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (v[k]) first_idx = 3'(k);
    end
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int k = 0; k < 4; k++) begin
      wmerge[8*k +: 8] = s[k] ? n[8*k +: 8] : o[8*k +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && ((a <= A_IEN) || (a >= A_PAT0 && a <= A_MSK1) ||
             (a >= A_TXWIN && a <= A_RXEND));
  endfunction

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = (p == 3'(NRX - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  function automatic logic [31:0] msg_word(input cmbf_frame_type f, input logic [7:0] mid,
                                           input logic [15:0] ts, input logic [1:0] w);
    case (w)
      2'h0:    msg_word = f.id;
      2'h1:    msg_word = f.data[63:32];
      2'h2:    msg_word = f.data[31:0];
      default: msg_word = {4'h0, f.dlc, mid, ts};
    endcase
  endfunction

  // register bus slave
  assign s_axi_awready_o = !aw_have_r && !bvalid_r;
  assign s_axi_wready_o  = !w_have_r && !bvalid_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign wr_en_w         = aw_have_r && w_have_r && !bvalid_r;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      wa_r          <= 8'h00;
      wd_r          <= 32'h00000000;
      ws_r          <= 4'h0;
      bvalid_r      <= 1'b0;
      s_axi_bresp_o <= RESP_OK;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_r <= 1'b1;
        wa_r      <= s_axi_awaddr_i;
      end else if (wr_en_w) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_r <= 1'b1;
        wd_r     <= s_axi_wdata_i;
        ws_r     <= s_axi_wstrb_i;
      end else if (wr_en_w) begin
        w_have_r <= 1'b0;
      end
      if (wr_en_w) begin
        bvalid_r      <= 1'b1;
        s_axi_bresp_o <= mapped(wa_r) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid_r      <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= RESP_OK;
    end else if (s_axi_arvalid_i && !rvalid_r) begin
      rvalid_r      <= 1'b1;
      s_axi_rdata_o <= rdat_w;
      s_axi_rresp_o <= mapped(s_axi_araddr_i) ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  assign tsel_w = 2'(first_idx({5'h0, sel_r}));
  assign head_w = fifo_r[rd_ptr_r];

  always_comb begin
    rdat_w = 32'h00000000;
    case (s_axi_araddr_i)
      A_CTRL:  rdat_w = ctrl_r;
      A_RXFLG: begin
        rdat_w[RXF_FULL]     = rx_cnt_r != 3'h0;
        rdat_w[RXF_OVR]      = ovr_r;
        rdat_w[RXF_HIT +: 3] = (rx_cnt_r != 3'h0) ? head_w.hit : 3'h0;
      end
      A_TXFLG: rdat_w[NTX-1:0] = empty_r;
      A_TXSEL: rdat_w[NTX-1:0] = sel_r;
      A_ABORT: begin
        rdat_w[NTX-1:0]         = abort_request_r;
        rdat_w[ABT_ACK +: NTX]  = abort_ack_r;
      end
      A_IEN:   rdat_w = ien_r;
      A_PAT0:  rdat_w = pat_r[0];
      A_PAT1:  rdat_w = pat_r[1];
      A_MSK0:  rdat_w = msk_r[0];
      A_MSK1:  rdat_w = msk_r[1];
      default: begin
        if (s_axi_araddr_i[7:4] == A_TXWIN[7:4] && |(sel_r & empty_r)) begin
          rdat_w = msg_word(txb_r[tsel_w].frm, txb_r[tsel_w].local_priority, txb_r[tsel_w].ts,
                            s_axi_araddr_i[3:2]);
        end else if (s_axi_araddr_i[7:4] == A_RXWIN[7:4] && rx_cnt_r != 3'h0) begin
          rdat_w = msg_word(head_w.frm, {5'h00, head_w.hit}, head_w.ts,
                            s_axi_araddr_i[3:2]);
        end
      end
    endcase
  end

  // configuration registers
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r   <= CTRL_RST;
      ien_r    <= IEN_RST;
      pat_r[0] <= PAT_RST;
      pat_r[1] <= PAT_RST;
      msk_r[0] <= MSK_RST;
      msk_r[1] <= MSK_RST;
    end else if (wr_en_w) begin
      case (wa_r)
        A_CTRL:  ctrl_r   <= wmerge(ctrl_r, wd_r, ws_r);
        A_IEN:   ien_r    <= wmerge(ien_r, wd_r, ws_r);
        A_PAT0:  pat_r[0] <= wmerge(pat_r[0], wd_r, ws_r);
        A_PAT1:  pat_r[1] <= wmerge(pat_r[1], wd_r, ws_r);
        A_MSK0:  msk_r[0] <= wmerge(msk_r[0], wd_r, ws_r);
        A_MSK1:  msk_r[1] <= wmerge(msk_r[1], wd_r, ws_r);
        default: ;
      endcase
    end
  end

  // transmit buffers
  generate
    for (genvar i = 0; i < NTX; i++) begin : g_txb
      logic [31:0] w3_w;
      assign w3_w = wmerge({4'h0, txb_r[i].frm.dlc, txb_r[i].local_priority, txb_r[i].ts}, wd_r, ws_r);
      always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          txb_r[i] <= '0;
        end else if (wr_en_w && sel_r[i] && empty_r[i] && wa_r[7:4] == A_TXWIN[7:4]) begin
          case (wa_r[3:2])
            2'h0:    txb_r[i].frm.id <= wmerge(txb_r[i].frm.id, wd_r, ws_r);
            2'h1:    txb_r[i].frm.data[63:32] <= wmerge(txb_r[i].frm.data[63:32], wd_r, ws_r);
            2'h2:    txb_r[i].frm.data[31:0] <= wmerge(txb_r[i].frm.data[31:0], wd_r, ws_r);
            default: begin
              txb_r[i].frm.dlc <= w3_w[27:24];
              txb_r[i].local_priority    <= w3_w[23:16];
            end
          endcase
        end else if (done_w[i] && ctrl_r[CTRL_TSEN]) begin
          txb_r[i].ts <= ts_i;
        end
      end
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < NTX; i++) begin
      done_w[i]     = tx_done_i && tx_active_r && tx_cur_r == 2'(i);
      abort_ok_w[i] = abort_request_r[i] && !empty_r[i] && !(tx_active_r && tx_cur_r == 2'(i));
    end
    txe_clr_w = (wr_en_w && wa_r == A_TXFLG && ws_r[0]) ? wd_r[NTX-1:0] : '0;
    abt_set_w = (wr_en_w && wa_r == A_ABORT && ws_r[0]) ? wd_r[NTX-1:0] : '0;
  end

  // empty, abort request and abort acknowledge flags; hardware set wins
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      empty_r <= TXE_RST;
      abort_ack_r <= '0;
      abort_request_r <= '0;
    end else begin
      for (int i = 0; i < NTX; i++) begin
        if (done_w[i] || abort_ok_w[i]) begin
          empty_r[i] <= 1'b1;
          abort_request_r[i] <= 1'b0;
        end else begin
          if (txe_clr_w[i]) empty_r[i] <= 1'b0;
          if (abt_set_w[i] && !empty_r[i]) abort_request_r[i] <= 1'b1;
        end
        if (abort_ok_w[i]) abort_ack_r[i] <= 1'b1;
        else if (done_w[i] || txe_clr_w[i]) abort_ack_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_r <= '0;
    end else if (wr_en_w && wa_r == A_TXSEL && ws_r[0]) begin
      sel_r <= |(wd_r[NTX-1:0] & empty_r) ?
               NTX'(3'h1 << first_idx({5'h0, wd_r[NTX-1:0] & empty_r})) : '0;
    end
  end

  // lowest value wins, strict compare keeps the lower index on ties
  always_comb begin
    best_w   = 2'h0;
    best_v_w = 1'b0;
    for (int i = 0; i < NTX; i++) begin
      if (!empty_r[i] && (!best_v_w || txb_r[i].local_priority < txb_r[best_w].local_priority)) begin
        best_w   = 2'(i);
        best_v_w = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_active_r <= 1'b0;
      tx_cur_r    <= 2'h0;
      tx_frame_o  <= '0;
    end else if (tx_arb_i && best_v_w) begin
      tx_active_r <= 1'b1;
      tx_cur_r    <= best_w;
      tx_frame_o  <= txb_r[best_w].frm;
    end else if (tx_done_i || tx_err_i || tx_lost_i) begin
      tx_active_r <= 1'b0;
    end
  end

  assign tx_pend_o = !(&empty_r);
  assign tx_irq_o  = |(empty_r & ien_r[NTX-1:0]);
  assign ack_en_o  = !tx_active_r || ctrl_r[CTRL_LOOP];

  // acceptance filter
  assign fmode_w = cmbf_fmode_type'(ctrl_r[CTRL_FMODE +: 2]);

  always_comb begin
    case (fmode_w)
      FM_FOUR:  idrep_w = {2{rx_frame_i.id[31:16]}};
      FM_EIGHT: idrep_w = {4{rx_frame_i.id[31:24]}};
      default:  idrep_w = rx_frame_i.id;
    endcase
  end

  generate
    for (genvar b = 0; b < 2; b++) begin : g_bank
      assign eq_w[b] = ~(idrep_w ^ pat_r[b]) | msk_r[b];
    end
  endgenerate

  always_comb begin
    hit_w = 8'h00;
    case (fmode_w)
      FM_TWO: begin
        for (int b = 0; b < 2; b++) hit_w[b] = &eq_w[b];
      end
      FM_FOUR: begin
        for (int b = 0; b < 2; b++) begin
          for (int h = 0; h < 2; h++) hit_w[2*b+h] = &eq_w[b][31-16*h -: 16];
        end
      end
      FM_EIGHT: begin
        for (int b = 0; b < 2; b++) begin
          for (int k = 0; k < 4; k++) hit_w[4*b+k] = &eq_w[b][31-8*k -: 8];
        end
      end
      default: hit_w = 8'h00;
    endcase
  end

  assign acc_w = rx_ok_i && |hit_w && fmode_w != FM_CLOSED &&
                 !(tx_active_r && !ctrl_r[CTRL_LOOP]);

  // background buffer, rewritten by every frame
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bg_r   <= '0;
      push_r <= 1'b0;
    end else begin
      push_r <= rx_eof_i && acc_w;
      if (rx_eof_i) begin
        bg_r.frm <= rx_frame_i;
        bg_r.hit <= first_idx(hit_w);
        bg_r.ts  <= ctrl_r[CTRL_TSEN] ? ts_i : 16'h0000;
      end
    end
  end

  assign pop_w = wr_en_w && wa_r == A_RXFLG && ws_r[0] && wd_r[RXF_FULL] &&
                 rx_cnt_r != 3'h0;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int s = 0; s < NRX; s++) fifo_r[s] <= '0;
      rd_ptr_r <= 3'h0;
      wr_ptr_r <= 3'h0;
      rx_cnt_r <= 3'h0;
    end else begin
      if (push_r && rx_cnt_r != 3'(NRX)) begin
        fifo_r[wr_ptr_r] <= bg_r;
        wr_ptr_r         <= ptr_inc(wr_ptr_r);
      end
      if (pop_w) rd_ptr_r <= ptr_inc(rd_ptr_r);
      rx_cnt_r <= rx_cnt_r + 3'((push_r && rx_cnt_r != 3'(NRX)) ? 1 : 0) -
                  3'(pop_w ? 1 : 0);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovr_r <= 1'b0;
    end else if (push_r && rx_cnt_r == 3'(NRX)) begin
      ovr_r <= 1'b1;
    end else if (wr_en_w && wa_r == A_RXFLG && ws_r[0] && wd_r[RXF_OVR]) begin
      ovr_r <= 1'b0;
    end
  end

  assign rx_irq_o  = rx_cnt_r != 3'h0 && ien_r[IEN_RX];
  assign ovr_irq_o = ovr_r && ien_r[IEN_OVR];

  // checks
  always_comb begin
    local_priority_ok_w = 1'b1;
    for (int j = 0; j < NTX; j++) begin
      if (!empty_r[j] && (txb_r[j].local_priority < txb_r[best_w].local_priority ||
          (txb_r[j].local_priority == txb_r[best_w].local_priority && 2'(j) < best_w))) local_priority_ok_w = 1'b0;
    end
  end

  sequence s_accept;
    rx_eof_i && acc_w;
  endsequence

  sequence s_room;
    rx_cnt_r != 3'(NRX) && !pop_w;
  endsequence

  a_local_priority_pick: assert property (tx_arb_i && best_v_w |-> local_priority_ok_w ##1
    (tx_active_r && tx_cur_r == $past(best_w))) else $error("wrong buffer picked");
  a_local_priority_tie: assert property (tx_arb_i && best_v_w && !empty_r[0] &&
    txb_r[0].local_priority == txb_r[best_w].local_priority |=> tx_cur_r == 2'h0) else $error("tie lost");
  a_retry_free: assert property (tx_err_i && !tx_arb_i |=> !tx_active_r)
    else $error("attempt not ended");
  a_done_free: assert property (tx_done_i && tx_active_r |=>
    empty_r[$past(tx_cur_r)] && !abort_ack_r[$past(tx_cur_r)]) else $error("send not released");
  a_abort_ack: assert property (|abort_ok_w |=>
    (abort_ack_r & empty_r & $past(abort_ok_w)) == $past(abort_ok_w)) else $error("abort lost");
  a_rx_push: assert property (s_accept ##1 s_room |=>
    rx_cnt_r == $past(rx_cnt_r) + 3'h1) else $error("frame not queued");
  a_rx_drop: assert property (rx_eof_i && !acc_w |=> !push_r)
    else $error("rejected frame queued");
  a_own_frame: assert property (rx_eof_i && tx_active_r && !ctrl_r[CTRL_LOOP]
    |=> !push_r) else $error("own frame queued");
  a_closed_none: assert property (fmode_w == FM_CLOSED && rx_eof_i |=> !push_r)
    else $error("closed filter accepted");
  a_ovr_full: assert property (s_accept ##1 (rx_cnt_r == 3'(NRX) && !pop_w) |=>
    ovr_r && rx_cnt_r == 3'(NRX)) else $error("overrun missed");
  a_hit_hold: assert property (rx_cnt_r != 3'h0 && !pop_w |=> $stable(head_w.hit))
    else $error("hit index changed");
endmodule

//--- core/cmbf_pkg.sv
// constants and types of the CAN message buffers and acceptance filter
// assumes a single 40 MHz clock shared with the protocol engine
package cmbf_pkg;
  localparam int NTX = 3;
  localparam int NRX = 5;
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_RXFLG = 8'h04;
  localparam logic [7:0] A_TXFLG = 8'h08;
  localparam logic [7:0] A_TXSEL = 8'h0C;
  localparam logic [7:0] A_ABORT = 8'h10;
  localparam logic [7:0] A_IEN   = 8'h14;
  localparam logic [7:0] A_PAT0  = 8'h20;
  localparam logic [7:0] A_PAT1  = 8'h24;
  localparam logic [7:0] A_MSK0  = 8'h28;
  localparam logic [7:0] A_MSK1  = 8'h2C;
  localparam logic [7:0] A_TXWIN = 8'h40;
  localparam logic [7:0] A_RXWIN = 8'h50;
  localparam logic [7:0] A_RXEND = 8'h5C;
  localparam int CTRL_LOOP  = 0;
  localparam int CTRL_TSEN  = 1;
  localparam int CTRL_FMODE = 4;
  localparam int RXF_FULL   = 0;
  localparam int RXF_OVR    = 1;
  localparam int RXF_HIT    = 8;
  localparam int ABT_ACK    = 4;
  localparam int IEN_RX     = 3;
  localparam int IEN_OVR    = 4;
  localparam logic [31:0]    CTRL_RST = 32'h00000000;
  localparam logic [31:0]    IEN_RST  = 32'h00000000;
  localparam logic [31:0]    PAT_RST  = 32'h00000000;
  localparam logic [31:0]    MSK_RST  = 32'h00000000;
  localparam logic [NTX-1:0] TXE_RST  = 3'h7;
  localparam logic [1:0]     RESP_OK  = 2'h0;
  localparam logic [1:0]     RESP_ERR = 2'h2;

  typedef enum logic [1:0] {FM_TWO, FM_FOUR, FM_EIGHT, FM_CLOSED} cmbf_fmode_type;

  typedef struct packed {
    logic [31:0] id;
    logic [63:0] data;
    logic [3:0]  dlc;
  } cmbf_frame_type;

  typedef struct packed {
    cmbf_frame_type frm;
    logic [7:0]     local_priority;
    logic [15:0]    ts;
  } cmbf_txbuf_type;

  typedef struct packed {
    cmbf_frame_type frm;
    logic [2:0]     hit;
    logic [15:0]    ts;
  } cmbf_rxmsg_type;
endpackage

//--- bench/cmbf_engine_model.sv
// behavioural protocol engine and bus traffic for cmbf_core
// assumes the testbench calls one task at a time
`timescale 1ns/100ps
module cmbf_engine_model (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_b_i,
  output logic                     tx_arb_o,
  output logic                     tx_done_o,
  output logic                     tx_err_o,
  output logic                     tx_lost_o,
  output logic                     rx_eof_o,
  output logic                     rx_ok_o,
  output cmbf_pkg::cmbf_frame_type rx_frame_o,
  output logic [15:0]              ts_o
);
  import cmbf_pkg::*;
  logic [3:0] ev;
  assign {tx_lost_o, tx_err_o, tx_done_o, tx_arb_o} = ev;
  initial begin
    ev = 4'h0;
    rx_eof_o = 1'b0;
    rx_ok_o = 1'b0;
    rx_frame_o = '0;
  end
  // free-running timer, one count per system clock
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) ts_o <= 16'h0000;
    else ts_o <= ts_o + 16'h0001;
  end
  // one-cycle event: 0 arb, 1 done, 2 err, 3 lost
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    ev <= 4'(1 << k);
    @(posedge clk_sys_i);
    ev <= 4'h0;
  endtask
  // end of one frame, lines scrambled afterwards
  task automatic frame(input logic [31:0] id, input logic good);
    @(posedge clk_sys_i);
    rx_frame_o <= '{id: id, data: 64'h0011223344556677, dlc: 4'h8};
    rx_ok_o <= good;
    rx_eof_o <= 1'b1;
    @(posedge clk_sys_i);
    rx_eof_o <= 1'b0;
    rx_ok_o <= ~good;
    rx_frame_o <= ~rx_frame_o;
  endtask
endmodule

//--- bench/testbench.sv
// self-checking bench for cmbf_core
// assumes cmbf_engine_model stands in for the protocol engine
`timescale 1ns/100ps
module testbench;
  import cmbf_pkg::*;
  logic           clk_sys_i, rst_b_i, awv, wv, bv, br, arv, rv, rr, awr, wrd, arr;
  logic           arb, dn, er, lo, eof, ok, pend, acken, txirq, rxirq, ovirq;
  logic [7:0]     awa, ara;
  logic [31:0]    wd, rd;
  logic [1:0]     bresp, rresp;
  logic [15:0]    ts;
  cmbf_frame_type txf, rx_full_flag;
  int             n_errors, total_checks;
  logic [15:0]    ts_eof, ts_done;
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  cmbf_core dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .tx_arb_i(arb),
    .tx_done_i(dn), .tx_err_i(er), .tx_lost_i(lo), .tx_pend_o(pend), .tx_frame_o(txf),
    .rx_eof_i(eof), .rx_ok_i(ok), .rx_frame_i(rx_full_flag), .ts_i(ts), .ack_en_o(acken),
    .tx_irq_o(txirq), .rx_irq_o(rxirq), .ovr_irq_o(ovirq));
  cmbf_engine_model eng (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .tx_arb_o(arb), .tx_done_o(dn), .tx_err_o(er),
    .tx_lost_o(lo), .rx_eof_o(eof), .rx_ok_o(ok), .rx_frame_o(rx_full_flag), .ts_o(ts));
  // timer values at the edges where the design stamps a buffer
  always @(posedge clk_sys_i) begin
    if (eof) ts_eof <= ts;
    if (dn) ts_done <= ts;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk_sys_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_sys_i);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv && br;
      r = bresp;
      @(posedge clk_sys_i);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) br <= 1'b0;
    end
    chk({30'h0, r}, {30'h0, RESP_OK});
  endtask
  // read, compare masked data and the response code
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic ta, t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys_i);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge clk_sys_i);
      ta = arv && arr;
      t = rv && rr;
      d = rd;
      r = rresp;
      @(posedge clk_sys_i);
      if (ta) arv <= 1'b0;
      if (t) rr <= 1'b0;
    end
    chk(d & m, e);
    chk({30'h0, r}, {30'h0, (a == 8'h7C) ? RESP_ERR : RESP_OK});
  endtask
  task automatic t_reset;
    rchk(A_TXFLG, {29'h0, TXE_RST}, 32'h7);
    rchk(A_CTRL, CTRL_RST, 32'hFFFFFFFF);
    rchk(8'h7C, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, txirq}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_tx;
    for (int i = 0; i < NTX; i++) begin
      axw(A_TXSEL, 32'(1 << i));
      axw(A_TXWIN, 32'(i + 1) << 28);
      axw(A_TXWIN + 8'h0C, {8'h08, (i == 0) ? 8'h05 : 8'h02, 16'h0000});
    end
    axw(A_IEN, 32'h0000_0007);
    axw(A_MSK0, 32'hFFFF_FFFF);
    axw(A_TXFLG, 32'h0000_0007);
    rchk(A_TXFLG, 32'h0, 32'h7);
    chk({31'h0, pend}, 32'h1);
    eng.pulse(0);
    @(negedge clk_sys_i);
    chk(txf.id, 32'h2000_0000);
    chk({31'h0, acken}, 32'h0);
    eng.frame(32'h2000_0000, 1'b1);
    rchk(A_RXFLG, 32'h0, 32'h1);
    axw(A_ABORT, 32'h0000_0006);
    rchk(A_TXFLG, 32'h4, 32'h7);
    eng.pulse(2);
    rchk(A_ABORT, 32'h60, 32'h70);
    eng.pulse(0);
    @(negedge clk_sys_i);
    chk(txf.id, 32'h1000_0000);
    eng.pulse(1);
    rchk(A_TXFLG, 32'h7, 32'h7);
    rchk(A_ABORT, 32'h60, 32'h70);
    chk({31'h0, txirq}, 32'h1);
    chk({31'h0, pend}, 32'h0);
    $display("test tx done");
  endtask
  task automatic t_rx;
    axw(A_PAT0, 32'hAAAA_0000);
    axw(A_MSK0, 32'h0000_000F);
    axw(A_PAT1, 32'h5555_0000);
    axw(A_IEN, 32'h0000_0018);
    eng.frame(32'h1234_0000, 1'b1);
    eng.frame(32'h5555_0000, 1'b0);
    rchk(A_RXFLG, 32'h0, 32'h1);
    eng.frame(32'h5555_0000, 1'b1);
    rchk(A_RXFLG, 32'h101, 32'h701);
    rchk(A_RXWIN, 32'h5555_0000, 32'hFFFFFFFF);
    chk({31'h0, rxirq}, 32'h1);
    for (int k = 1; k < 6; k++) eng.frame(32'hAAAA_0000 | 32'(k), 1'b1);
    rchk(A_RXFLG, 32'h103, 32'h703);
    chk({31'h0, ovirq}, 32'h1);
    axw(A_RXFLG, 32'h0000_0003);
    rchk(A_RXFLG, 32'h001, 32'h703);
    eng.frame(32'hAAAA_0002, 1'b1);
    for (int k = 0; k < 4; k++) axw(A_RXFLG, 32'h0000_0001);
    rchk(A_RXFLG, 32'h001, 32'h001);
    axw(A_RXFLG, 32'h0000_0001);
    rchk(A_RXFLG, 32'h0, 32'h701);
    axw(A_MSK0, 32'h0000_0000);
    axw(A_PAT0, 32'hFFFF_0123);
    axw(A_PAT1, 32'h0123_4567);
    for (int m = 0; m < 4; m++) begin
      axw(A_CTRL, 32'(m) << CTRL_FMODE);
      eng.frame(32'h0123_4567, 1'b1);
      rchk(A_RXFLG, (m == 3) ? 32'h0 : (m == 2) ? 32'h201 : 32'h101,
           32'h701);
      axw(A_RXFLG, 32'h0000_0001);
    end
    $display("test rx done");
  endtask
  task automatic t_loop;
    axw(A_CTRL, 32'h0000_0003);
    axw(A_TXSEL, 32'h0000_0001);
    axw(A_TXWIN, 32'h0123_4567);
    axw(A_TXFLG, 32'h0000_0001);
    eng.pulse(0);
    @(negedge clk_sys_i);
    chk({31'h0, acken}, 32'h1);
    eng.frame(32'h0123_4567, 1'b1);
    eng.pulse(1);
    rchk(A_RXFLG, 32'h101, 32'h701);
    rchk(A_RXWIN + 8'h0C, {16'h0801, ts_eof}, 32'hFFFF_FFFF);
    rchk(A_TXWIN + 8'h0C, {16'h0805, ts_done}, 32'hFFFF_FFFF);
    axw(A_RXFLG, 32'h0000_0001);
    axw(A_CTRL, 32'h0000_0000);
    axw(A_TXFLG, 32'h0000_0001);
    eng.pulse(0);
    eng.pulse(3);
    @(negedge clk_sys_i);
    chk({31'h0, acken}, 32'h1);
    eng.frame(32'h0123_4567, 1'b1);
    rchk(A_RXFLG, 32'h101, 32'h701);
    rchk(A_RXWIN + 8'h0C, 32'h0801_0000, 32'hFFFF_FFFF);
    $display("test loop done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {rst_b_i, awv, wv, br, arv, rr, awa, ara, wd} = '0;
    n_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_loop;
    tally_and_finish;
  end
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish;
  end
endmodule
